// ### rtl/pil_indicator.sv
// bin indicator state logic with axi4-lite register slave
// assumes sensor pins asynchronous, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none

module pil_indicator #(
    parameter int DIV_MS = pil_pkg::CYC_PER_MS
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic touch_i,
    input wire logic optical_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] state_o,
    output pil_pkg::pil_light_s light_o,
    output logic irq_o
);

    // refuse divider values the counter cannot hold
    if (DIV_MS < 2 || DIV_MS >= (1 << pil_pkg::DIV_W)) begin : g_chk
        $error("DIV_MS out of range");
    end

    localparam logic [pil_pkg::DIV_W-1:0] DIV_LAST =
        pil_pkg::DIV_W'(DIV_MS - 1);

    pil_pkg::pil_state_s q;
    pil_pkg::pil_state_s d;
    logic tch;
    logic opt;
    logic sens;
    logic tick;
    logic wr_go;
    logic ar_go;
    logic [31:0] w_m;
    logic [31:0] w_old;
    logic [IRQ_CLR_W-1:0] unused_clr;
    localparam int IRQ_CLR_W = 1;
    logic [pil_pkg::IRQ_N-1:0] ev;

    // synchronised sensor levels
    assign tch = q.tch_s[1];
    assign opt = q.opt_s[1];
    assign sens = tch | opt;
    assign tick = (q.div_cnt == DIV_LAST);

    // bus handshakes
    assign s_axi_awready = !q.aw_h && !q.bv;
    assign s_axi_wready = !q.w_h && !q.bv;
    assign s_axi_arready = !q.rv;
    assign wr_go = q.aw_h && q.w_h && !q.bv;
    assign ar_go = s_axi_arvalid && !q.rv;
    assign unused_clr = '0;

    // old value of the word being written
    always_comb begin
        case (q.aw_a)
            pil_pkg::OFS_JOB: w_old = {16'h0000, q.job};
            pil_pkg::OFS_ON_DLY: w_old = {16'h0000, q.on_dly};
            pil_pkg::OFS_APPEAR: w_old = {7'h00, q.appear};
            pil_pkg::OFS_IRQ_MK: w_old = {29'h0, q.irq_mk};
            default: w_old = 32'h0000_0000;
        endcase
    end

    // byte-lane merge of write data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            w_m[i*8 +: 8] = q.w_s[i] ? q.w_d[i*8 +: 8] : w_old[i*8 +: 8];
        end
    end

    // next state of the whole module
    always_comb begin
        d = q;
        ev = '0;
        d.tch_s = {q.tch_s[0], touch_i};
        d.opt_s = {q.opt_s[0], optical_i};

        // on-delay counting in idle, divider restarts with it
        if (q.st == pil_pkg::ST_IDLE && sens && q.job == 16'h0000) begin
            d.div_cnt = tick ? '0 : q.div_cnt + 1'b1;
            if (tick && q.dly_cnt != 16'hffff) begin
                d.dly_cnt = q.dly_cnt + 16'h0001;
            end
        end else begin
            d.div_cnt = '0;
            d.dly_cnt = 16'h0000;
        end

        // indicator state machine
        case (q.st)
            pil_pkg::ST_IDLE: begin
                if (q.job != 16'h0000) begin
                    if (!sens) begin
                        d.st = pil_pkg::ST_ACTIVE;
                    end
                end else if (sens && q.dly_cnt >= q.on_dly) begin
                    d.st = pil_pkg::ST_WRONG;
                    ev[pil_pkg::IRQ_WRONG] = 1'b1;
                end
            end
            pil_pkg::ST_WRONG: begin
                if (!sens) begin
                    d.st = (q.job != 16'h0000) ? pil_pkg::ST_ACTIVE
                                               : pil_pkg::ST_IDLE;
                end
            end
            pil_pkg::ST_ACTIVE: begin
                if (q.job == 16'h0000) begin
                    d.st = sens ? pil_pkg::ST_WRONG
                                : pil_pkg::ST_IDLE;
                    ev[pil_pkg::IRQ_WRONG] = sens;
                end else if (tch) begin
                    d.st = pil_pkg::ST_CONF_T;
                    ev[pil_pkg::IRQ_CONF_T] = 1'b1;
                end else if (opt) begin
                    d.st = pil_pkg::ST_CONF_O;
                    ev[pil_pkg::IRQ_CONF_O] = 1'b1;
                end
            end
            pil_pkg::ST_CONF_T, pil_pkg::ST_CONF_O: begin
                if (q.job == 16'h0000) begin
                    d.st = sens ? pil_pkg::ST_WRONG
                                : pil_pkg::ST_IDLE;
                    ev[pil_pkg::IRQ_WRONG] = sens;
                end
            end
            default: begin
                d.st = pil_pkg::ST_IDLE;
            end
        endcase

        // light output for the coming state
        d.light = '0;
        case (d.st)
            pil_pkg::ST_WRONG: begin
                d.light.colour = pil_pkg::COL_RED;
                d.light.anim = pil_pkg::ANI_FLASH;
                d.light.intensity = pil_pkg::INT_FULL;
            end
            pil_pkg::ST_ACTIVE: begin
                d.light = q.appear;
            end
            pil_pkg::ST_CONF_T, pil_pkg::ST_CONF_O: begin
                d.light.colour = pil_pkg::COL_YELLOW;
                d.light.anim = pil_pkg::ANI_STEADY;
                d.light.intensity = pil_pkg::INT_FULL;
            end
            default: begin
                d.light = '0;
            end
        endcase

        // write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_h = 1'b1;
            d.aw_a = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_h = 1'b1;
            d.w_d = s_axi_wdata;
            d.w_s = s_axi_wstrb;
        end

        // sticky events, set wins over write-one clear
        d.irq_st = q.irq_st | ev;

        // register write
        if (wr_go) begin
            d.aw_h = 1'b0;
            d.w_h = 1'b0;
            d.bv = 1'b1;
            d.br = pil_pkg::RESP_OKAY;
            case (q.aw_a)
                pil_pkg::OFS_JOB: d.job = w_m[15:0];
                pil_pkg::OFS_ON_DLY: d.on_dly = w_m[15:0];
                pil_pkg::OFS_APPEAR: d.appear = w_m[24:0];
                pil_pkg::OFS_IRQ_MK: d.irq_mk = w_m[pil_pkg::IRQ_N-1:0];
                pil_pkg::OFS_STATUS: begin
                end
                pil_pkg::OFS_IRQ_ST: begin
                    if (q.w_s[0]) begin
                        d.irq_st = (q.irq_st
                            & ~q.w_d[pil_pkg::IRQ_N-1:0]) | ev;
                    end
                end
                default: d.br = pil_pkg::RESP_SLVERR;
            endcase
        end else if (q.bv && s_axi_bready) begin
            d.bv = 1'b0;
        end

        // register read
        if (ar_go) begin
            d.rv = 1'b1;
            d.rr = pil_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                pil_pkg::OFS_JOB: d.rd = {16'h0000, q.job};
                pil_pkg::OFS_ON_DLY: d.rd = {16'h0000, q.on_dly};
                pil_pkg::OFS_APPEAR: d.rd = {7'h00, q.appear};
                pil_pkg::OFS_STATUS: begin
                    d.rd = {29'h0, q.st};
                    d.rd[pil_pkg::STS_TOUCH] = tch;
                    d.rd[pil_pkg::STS_OPTIC] = opt;
                end
                pil_pkg::OFS_IRQ_ST: d.rd = {29'h0, q.irq_st};
                pil_pkg::OFS_IRQ_MK: d.rd = {29'h0, q.irq_mk};
                default: begin
                    d.rd = 32'h0000_0000;
                    d.rr = pil_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q.rv && s_axi_rready) begin
            d.rv = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.on_dly <= pil_pkg::ON_DLY_RST;
            q.appear <= pil_pkg::APPEAR_RST;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign s_axi_bvalid = q.bv;
    assign s_axi_bresp = q.br;
    assign s_axi_rvalid = q.rv;
    assign s_axi_rdata = q.rd;
    assign s_axi_rresp = q.rr;
    assign state_o = q.st;
    assign light_o = q.light;
    assign irq_o = |(q.irq_st & q.irq_mk);

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    a_idle_light_off: assert property (
        q.st == pil_pkg::ST_IDLE |-> q.light == '0)
        else $error("idle state shows light");

    a_wrong_needs_dly: assert property (
        q.st == pil_pkg::ST_IDLE && q.dly_cnt < q.on_dly
        |=> q.st != pil_pkg::ST_WRONG)
        else $error("wrong-bin before on-delay");

    a_wrong_ends_rel: assert property (
        q.st == pil_pkg::ST_WRONG && !sens && q.job == 16'h0000
        |=> q.st == pil_pkg::ST_IDLE ##0 q.light == '0)
        else $error("wrong-bin outlived sensor");

    a_wrong_red_flash: assert property (
        q.st == pil_pkg::ST_WRONG
        |-> q.light.colour == pil_pkg::COL_RED
            && q.light.anim == pil_pkg::ANI_FLASH)
        else $error("wrong-bin not flashing red");

    a_job_to_active: assert property (
        q.st == pil_pkg::ST_IDLE && q.job != 16'h0000 && !sens
        |=> q.st == pil_pkg::ST_ACTIVE)
        else $error("job did not activate");

    a_active_appear: assert property (
        q.st == pil_pkg::ST_ACTIVE && $stable(q.appear)
        |-> q.light == q.appear)
        else $error("active light not from settings");

    a_touch_confirm: assert property (
        q.st == pil_pkg::ST_ACTIVE && q.job != 16'h0000 && tch
        |=> q.st == pil_pkg::ST_CONF_T
            && q.light.colour == pil_pkg::COL_YELLOW)
        else $error("touch did not confirm");

    a_optic_confirm: assert property (
        q.st == pil_pkg::ST_ACTIVE && q.job != 16'h0000 && !tch && opt
        |=> q.st == pil_pkg::ST_CONF_O ##1 q.irq_st[pil_pkg::IRQ_CONF_O])
        else $error("optical did not confirm");

    a_job_clear_exit: assert property (
        (q.st == pil_pkg::ST_ACTIVE || q.st == pil_pkg::ST_CONF_T
         || q.st == pil_pkg::ST_CONF_O) && q.job == 16'h0000
        |=> q.st == ($past(sens) ? pil_pkg::ST_WRONG : pil_pkg::ST_IDLE))
        else $error("job clear did not exit");

    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##[0:1] s_axi_bvalid)
        else $error("write not answered");

    c_wrong_entry: cover property (
        q.st == pil_pkg::ST_IDLE ##1 q.st == pil_pkg::ST_WRONG);
    c_touch_ack: cover property (
        q.st == pil_pkg::ST_ACTIVE ##1 q.st == pil_pkg::ST_CONF_T);
    c_optic_ack: cover property (
        q.st == pil_pkg::ST_ACTIVE ##1 q.st == pil_pkg::ST_CONF_O);
    c_irq_raise: cover property ($rose(irq_o));

endmodule : pil_indicator

`default_nettype wire

// ### rtl/pil_pkg.sv
// constants, types and register map of the bin indicator state logic
// assumes one 125 MHz clock and an AXI4-Lite master for software access
//
// Overview of operation
// - idle when no job and no sensor active; light off.
// - idle plus sensor enters wrong-bin only after the set on-delay.
// - wrong-bin lasts while the sensor is held; flashing red.
// - nonzero job and no sensor gives active-pick; steady green by default.
// - active-pick drives animation, colour, intensity, speed, pattern, direction.
// - sensor actuated in active-pick gives confirmed-pick; steady yellow.
// - second confirmed state tells optical confirmation from touch.
package pil_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_JOB = 8'h00;
    localparam logic [7:0] OFS_ON_DLY = 8'h04;
    localparam logic [7:0] OFS_APPEAR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST = 8'h10;
    localparam logic [7:0] OFS_IRQ_MK = 8'h14;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing: on-delay counted in milliseconds
    localparam int CLK_PERIOD_NS = 8;
    localparam int DLY_UNIT_NS = 1000000;
    localparam int CYC_PER_MS = DLY_UNIT_NS / CLK_PERIOD_NS;
    localparam int DIV_W = 20;
    localparam logic [15:0] ON_DLY_RST = 16'h0032;

    // colour and animation codes
    localparam logic [3:0] COL_OFF = 4'h0;
    localparam logic [3:0] COL_GREEN = 4'h1;
    localparam logic [3:0] COL_RED = 4'h2;
    localparam logic [3:0] COL_YELLOW = 4'h3;
    localparam logic [3:0] ANI_OFF = 4'h0;
    localparam logic [3:0] ANI_STEADY = 4'h1;
    localparam logic [3:0] ANI_FLASH = 4'h2;
    localparam logic [7:0] INT_FULL = 8'hff;

    // interrupt bit positions
    localparam int IRQ_WRONG = 0;
    localparam int IRQ_CONF_T = 1;
    localparam int IRQ_CONF_O = 2;
    localparam int IRQ_N = 3;

    // status register field positions
    localparam int STS_TOUCH = 3;
    localparam int STS_OPTIC = 4;

    // indicator states, gray along idle, active, touch-confirmed, optical-confirmed
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACTIVE = 3'h1,
        ST_CONF_T = 3'h3,
        ST_CONF_O = 3'h2,
        ST_WRONG = 3'h6
    } pil_fsm_e;

    // light settings, lsb first: anim, colour, intensity, speed, ...
    typedef struct packed {
        logic dir;
        logic [3:0] pattern;
        logic [3:0] speed;
        logic [7:0] intensity;
        logic [3:0] colour;
        logic [3:0] anim;
    } pil_light_s;

    localparam pil_light_s APPEAR_RST = '{1'b0, 4'h0, 4'h0, INT_FULL,
                                          COL_GREEN, ANI_STEADY};

    // complete module state
    typedef struct packed {
        logic [1:0] tch_s;
        logic [1:0] opt_s;
        pil_fsm_e st;
        logic [15:0] dly_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic [15:0] job;
        logic [15:0] on_dly;
        pil_light_s appear;
        pil_light_s light;
        logic [IRQ_N-1:0] irq_st;
        logic [IRQ_N-1:0] irq_mk;
        logic aw_h;
        logic [7:0] aw_a;
        logic w_h;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } pil_state_s;

endpackage : pil_pkg

// ### sim/pil_sensor_model.sv
// touch and optical sensor model for the bin indicator bench
// assumes press requests come from the bench on clock edges
`timescale 1ns/100ps
`default_nettype none

module pil_sensor_model #(
    parameter int LAG = 1
) (
    input wire logic clock_i,
    input wire logic press_touch_i,
    input wire logic press_optic_i,
    output logic touch_o,
    output logic optical_o
);
    logic [LAG:0] t_q;
    logic [LAG:0] o_q;

    // lagged contact, a slow sensor is a larger LAG
    always_ff @(posedge clock_i) begin
        t_q <= {t_q[LAG-1:0], press_touch_i};
        o_q <= {o_q[LAG-1:0], press_optic_i};
    end
    assign touch_o = t_q[LAG];
    assign optical_o = o_q[LAG];
endmodule : pil_sensor_model

`default_nettype wire

// ### sim/pil_indicator_test.sv
// self-checking bench of the bin indicator state logic
// assumes 125 MHz clock, DIV_MS shortened to 4 cycles per ms
`timescale 1ns/100ps
`default_nettype none

module pil_indicator_test;
    typedef struct packed {
        logic [15:0] job;
        logic t;
        logic o;
        logic [2:0] st;
        logic [7:0] lt;
    } pil_row_s;
    logic clock_i, reset_n_i, pt, po, touch, optic;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic arvalid, arready, rvalid, rready, irq;
    logic [2:0] state;
    pil_pkg::pil_light_s light;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    pil_row_s rows [9] = '{
        '{16'h0000, 1'b0, 1'b0, 3'h0, 8'h00}, '{16'h0005, 1'b0, 1'b0, 3'h1, 8'h11},
        '{16'h0005, 1'b1, 1'b0, 3'h3, 8'h31}, '{16'h0005, 1'b0, 1'b0, 3'h3, 8'h31},
        '{16'h0000, 1'b0, 1'b0, 3'h0, 8'h00}, '{16'h0001, 1'b0, 1'b0, 3'h1, 8'h11},
        '{16'h0001, 1'b0, 1'b1, 3'h2, 8'h31}, '{16'h0000, 1'b0, 1'b1, 3'h6, 8'h22},
        '{16'h0000, 1'b0, 1'b0, 3'h0, 8'h00}};

    pil_sensor_model pil_sensor_model_inst (.clock_i(clock_i),
        .press_touch_i(pt), .press_optic_i(po), .touch_o(touch),
        .optical_o(optic));

    pil_indicator #(.DIV_MS(4)) pil_indicator_inst (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .touch_i(touch), .optical_i(optic),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .state_o(state), .light_o(light),
        .irq_o(irq));

    // clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk

    // one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit hold;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hold = 1'b1;
        while (hold) begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                hold = 1'b0;
            end
        end
    endtask : wr

    // one read
    task automatic rdr(input logic [7:0] a);
        bit hold;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hold = 1'b1;
        while (hold) begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                hold = 1'b0;
            end
        end
    endtask : rdr

    task automatic press(input logic t, input logic o, input int n);
        pt <= t;
        po <= o;
        repeat (n) @(posedge clock_i);
    endtask : press

    // main sequence
    initial begin
        reset_n_i = 1'b0;
        {pt, po, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        chk("rst state", 32'h0, {29'h0, state});
        chk("rst light", 32'h0, {7'h0, light});
        rdr(pil_pkg::OFS_ON_DLY);
        chk("rst on_dly", 32'h32, rd);
        rdr(pil_pkg::OFS_APPEAR);
        chk("rst appear", 32'h0ff11, rd);
        // table of job and sensor steps
        for (int i = 0; i < 9; i++) begin
            wr(pil_pkg::OFS_JOB, {16'h0, rows[i].job});
            press(rows[i].t, rows[i].o, 6);
            chk("row state", {29'h0, rows[i].st}, {29'h0, state});
            chk("row light", {24'h0, rows[i].lt}, {24'h0, light[7:0]});
        end
        chk("irq masked", 32'h0, {31'h0, irq});
        rdr(pil_pkg::OFS_IRQ_ST);
        chk("conf events", 32'h6, rd & 32'h6);
        wr(pil_pkg::OFS_IRQ_ST, 32'h7);
        rdr(pil_pkg::OFS_IRQ_ST);
        chk("w1c", 32'h0, rd);
        // brief touch is filtered
        wr(pil_pkg::OFS_ON_DLY, 32'h2);
        press(1'b1, 1'b0, 3);
        press(1'b0, 1'b0, 20);
        chk("brief", 32'h0, {29'h0, state});
        // long touch enters wrong-bin after the delay
        press(1'b1, 1'b0, 6);
        chk("early", 32'h0, {29'h0, state});
        press(1'b1, 1'b0, 14);
        chk("wrong", 32'h6, {29'h0, state});
        chk("wrong lt", 32'h22, {24'h0, light[7:0]});
        wr(pil_pkg::OFS_IRQ_MK, 32'h1);
        @(posedge clock_i);
        chk("irq on", 32'h1, {31'h0, irq});
        press(1'b0, 1'b0, 6);
        chk("release", 32'h0, {29'h0, state});
        wr(pil_pkg::OFS_IRQ_ST, 32'h1);
        @(posedge clock_i);
        chk("irq off", 32'h0, {31'h0, irq});
        // own appearance in active-pick
        wr(pil_pkg::OFS_APPEAR, 32'h01a5c743);
        wr(pil_pkg::OFS_JOB, 32'h3);
        repeat (3) @(posedge clock_i);
        chk("appear", 32'h01a5c743, {7'h0, light});
        // read-only and unmapped places
        wr(pil_pkg::OFS_STATUS, 32'h7);
        chk("ro resp", {30'h0, pil_pkg::RESP_OKAY}, {30'h0, rs});
        rdr(pil_pkg::OFS_STATUS);
        chk("status", 32'h1, rd & 32'h7);
        rdr(8'h18);
        chk("unmapped", {30'h0, pil_pkg::RESP_SLVERR}, {30'h0, rs});
        chk("unmapped rd", 32'h0, rd);
        print_verdict();
    end
endmodule : pil_indicator_test

`default_nettype wire
